// >>> rac_pkg.sv
package rac_pkg;
    // ------------------------------------------------------------
    // object classes and services
    // ------------------------------------------------------------
    localparam logic [7:0] RAC_CLASS_CFG = 8'h00_BE;
    localparam logic [7:0] RAC_CLASS_IO = 8'h00_67;
    localparam logic [7:0] RAC_CLASS_ACT = 8'h00_6A;
    localparam logic [7:0] RAC_SVC_GET = 8'h00_0E;
    localparam logic [7:0] RAC_SVC_SET = 8'h00_10;
    localparam logic [7:0] RAC_SVC_ERR_ATTR = 8'h00_14;
    localparam logic [7:0] RAC_SVC_ERR_SVC = 8'h00_08;
    localparam logic [7:0] RAC_SVC_OK = 8'h00_00;
    // ------------------------------------------------------------
    // configuration record (attribute = byte index)
    // ------------------------------------------------------------
    localparam int RAC_CFG_LEN = 3;
    localparam logic [7:0] RAC_CFG_ACK_MODE_BYTE = 8'h00_00;
    localparam logic [7:0] RAC_CFG_RESULT_FRAG_BYTE = 8'h00_01;
    localparam logic [7:0] RAC_CFG_ENTRY_FRAG_BYTE = 8'h00_02;
    localparam int RAC_CFG_EN_BIT = 0;
    localparam logic [7:0] RAC_CFG_RESET = 8'h00_00;
    // ------------------------------------------------------------
    // switching channel attributes (instance 1, 2)
    // ------------------------------------------------------------
    localparam logic [7:0] RAC_IO_PIN_LEVEL = 8'h00_05;
    localparam logic [7:0] RAC_IO_OUT_DRIVE = 8'h00_06;
    localparam logic [7:0] RAC_IO_CNT_CLEAR = 8'h00_07;
    localparam logic [7:0] RAC_IO_CMP_EXCEEDED = 8'h00_08;
    localparam logic [7:0] RAC_IO_CMP_TOGGLE = 8'h00_09;
    // ------------------------------------------------------------
    // activation attributes (instance 1)
    // ------------------------------------------------------------
    localparam logic [7:0] RAC_ACT_MODE = 8'h00_01;
    localparam logic [7:0] RAC_ACT_PENDING = 8'h00_02;
    localparam logic [7:0] RAC_ACT_GATE = 8'h00_03;
    localparam logic [7:0] RAC_ACT_ACK = 8'h00_04;
    localparam logic [7:0] RAC_ACT_CLEAR = 8'h00_05;
    // ------------------------------------------------------------
    // controller register map (own port)
    // ------------------------------------------------------------
    localparam logic [3:0] RAC_REG_CLASS = 4'h0;
    localparam logic [3:0] RAC_REG_INST = 4'h1;
    localparam logic [3:0] RAC_REG_ATTR = 4'h2;
    localparam logic [3:0] RAC_REG_WDATA = 4'h3;
    localparam logic [3:0] RAC_REG_CMD = 4'h4;
    localparam logic [3:0] RAC_REG_STATUS = 4'h5;
    localparam logic [3:0] RAC_REG_RDATA = 4'h6;
    localparam logic [3:0] RAC_REG_CFGSEND = 4'h7;
    localparam int RAC_CMD_GET_BIT = 0;
    localparam int RAC_CMD_SET_BIT = 1;

    // written bit of an attribute
    function automatic logic rac_bit0(input logic [7:0] v);
        return v[0];
    endfunction
endpackage

// >>> rac_link_if.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// explicit-message link between controller and reader
// ------------------------------------------------------------
interface rac_link_if;
    logic req;
    logic [7:0] service;
    logic [7:0] class_id;
    logic [7:0] instance_id;
    logic [7:0] attr_id;
    logic [7:0] wdata;
    logic rsp;
    logic [7:0] rsp_status;
    logic [7:0] rdata;

    modport controller (output req, output service, output class_id, output instance_id,
        output attr_id, output wdata, input rsp, input rsp_status, input rdata);
    modport reader (input req, input service, input class_id, input instance_id,
        input attr_id, input wdata, output rsp, output rsp_status, output rdata);
endinterface
`default_nettype wire

// >>> rac_channel.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// one switching channel: drive, counter, compare
// ------------------------------------------------------------
module rac_channel
    import rac_pkg::*;
#(
    parameter int CNT_W = 16
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic event_pulse,
    input wire logic [CNT_W-1:0] compare_value,
    input wire logic repeat_mode,
    input wire logic drive_we,
    input wire logic clear_we,
    input wire logic wbit,
    output logic drive_r,
    output logic clear_bit_r,
    output logic exceeded_r,
    output logic toggle_r
);
    logic [CNT_W-1:0] count_r;
    logic clear_rise;
    logic over_now;

    assign clear_rise = clear_we && wbit && !clear_bit_r;
    assign over_now = (count_r > compare_value);

    // output activation bit
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            drive_r <= 1'b0;
        end else if (drive_we) begin
            drive_r <= wbit;
        end
    end

    // clear-control bit, only its rising edge acts
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            clear_bit_r <= 1'b0;
        end else if (clear_we) begin
            clear_bit_r <= wbit;
        end
    end

    // event counter
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            count_r <= '0;
        end else if (clear_rise) begin
            count_r <= '0;
        end else if (event_pulse && count_r != '1) begin
            count_r <= count_r + 1'b1;
        end
    end

    // compare flag and toggle
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            exceeded_r <= 1'b0;
            toggle_r <= 1'b0;
        end else if (clear_rise) begin
            exceeded_r <= 1'b0;
            toggle_r <= 1'b0;
        end else begin
            exceeded_r <= over_now;
            if (repeat_mode && event_pulse && over_now) begin
                toggle_r <= !toggle_r;
            end else if (!exceeded_r && over_now) begin
                toggle_r <= !toggle_r;
            end
        end
    end
endmodule
`default_nettype wire

// >>> rac_reader.sv
`timescale 1ns/10ps
`default_nettype none
// Functional notes
// - configuration record is exactly three bytes
// - byte 0 bit 0 selects acknowledge mode
// - byte 1 bit 0 enables result fragmentation
// - byte 2 bit 0 enables entry fragmentation
// - configuration bytes reset to zero
// - io object class 0x67, get/set
// - channel attributes one to four unsupported
// - status attribute reports channel pin level
// - output activation drives switching output
// - counter clear on rising edge only
// - compare flag set when counter exceeds
// - toggle inverts on each exceedance
// - toggle bits act on edges
// - activation object class 0x6A, get/set
// - handshake mode waits for acknowledge
// - last acknowledge zeroes input area
// - eight-bit pending result count
// - gate opens on rise, closes on fall
// - any acknowledge change means processed
// - data clear rise discards all results
module rac_reader
    import rac_pkg::*;
#(
    parameter int CNT_W = 16,
    parameter int CHANNELS = 2
) (
    input wire logic clk_sys,
    input wire logic reset_n,
    rac_link_if.reader link,
    input wire logic [CHANNELS-1:0] switched_channel_pin,
    input wire logic [CHANNELS-1:0] channel_event,
    input wire logic [CNT_W-1:0] compare_value,
    input wire logic repeat_mode,
    input wire logic result_new,
    input wire logic [7:0] result_byte,
    output logic [CHANNELS-1:0] switching_output,
    output logic reading_gate_open,
    output logic [7:0] input_area,
    output logic input_area_valid,
    output logic ack_mode,
    output logic result_fragment_en,
    output logic entry_fragment_en
);
    // ------------------------------------------------------------
    // synchronisers and decode
    // ------------------------------------------------------------
    logic [CHANNELS-1:0] pin_s1_r, pin_s2_r, ev_s1_r, ev_s2_r, ev_d_r;
    logic [CHANNELS-1:0] drive_w, clr_w, exc_w, tog_w, drive_we, clr_we;
    logic [7:0] pending_r;
    logic gate_bit_r, ack_bit_r, clear_bit_r, ack_mode_r;
    logic [7:0] shown_r, queued_r;
    logic shown_valid_r;
    logic set_ok, is_set, is_get, is_cfg, is_io, is_act, ch_ok, wbit;
    logic ack_event, clear_rise, take_new;
    logic [7:0] rd_val, st_val;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pin_s1_r <= '0;
            pin_s2_r <= '0;
            ev_s1_r <= '0;
            ev_s2_r <= '0;
            ev_d_r <= '0;
        end else begin
            pin_s1_r <= switched_channel_pin;
            pin_s2_r <= pin_s1_r;
            ev_s1_r <= channel_event;
            ev_s2_r <= ev_s1_r;
            ev_d_r <= ev_s2_r;
        end
    end

    assign is_get = link.req && link.service == RAC_SVC_GET;
    assign is_set = link.req && link.service == RAC_SVC_SET;
    assign is_cfg = link.class_id == RAC_CLASS_CFG;
    assign is_io = link.class_id == RAC_CLASS_IO;
    assign is_act = link.class_id == RAC_CLASS_ACT;
    assign ch_ok = link.instance_id != 8'h00_00 && link.instance_id <= 8'(CHANNELS);
    assign wbit = rac_bit0(link.wdata);
    assign set_ok = is_set && st_val == RAC_SVC_OK;
    assign ack_event = set_ok && is_act && link.attr_id == RAC_ACT_ACK && wbit != ack_bit_r;
    assign clear_rise = set_ok && is_act && link.attr_id == RAC_ACT_CLEAR && wbit && !clear_bit_r;

    // ------------------------------------------------------------
    // switching channels
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < CHANNELS; gi++) begin : g_ch
            assign drive_we[gi] = set_ok && is_io && link.instance_id == 8'(gi + 1)
                && link.attr_id == RAC_IO_OUT_DRIVE;
            assign clr_we[gi] = set_ok && is_io && link.instance_id == 8'(gi + 1)
                && link.attr_id == RAC_IO_CNT_CLEAR;
            rac_channel #(.CNT_W(CNT_W)) rac_channel_inst (
                .clk_sys(clk_sys),
                .reset_n(reset_n),
                .event_pulse(ev_s2_r[gi] && !ev_d_r[gi]),
                .compare_value(compare_value),
                .repeat_mode(repeat_mode),
                .drive_we(drive_we[gi]),
                .clear_we(clr_we[gi]),
                .wbit(wbit),
                .drive_r(drive_w[gi]),
                .clear_bit_r(clr_w[gi]),
                .exceeded_r(exc_w[gi]),
                .toggle_r(tog_w[gi])
            );
        end
    endgenerate

    // ------------------------------------------------------------
    // attribute status and read value
    // ------------------------------------------------------------
    always_comb begin
        st_val = RAC_SVC_OK;
        rd_val = 8'h00_00;
        if (link.service != RAC_SVC_GET && link.service != RAC_SVC_SET) begin
            st_val = RAC_SVC_ERR_SVC;
        end else if (is_cfg && link.attr_id < 8'(RAC_CFG_LEN)) begin
            unique case (link.attr_id)
                RAC_CFG_ACK_MODE_BYTE: rd_val = {7'h00, ack_mode_r};
                RAC_CFG_RESULT_FRAG_BYTE: rd_val = {7'h00, result_fragment_en};
                default: rd_val = {7'h00, entry_fragment_en};
            endcase
        end else if (is_io && ch_ok && link.attr_id >= RAC_IO_PIN_LEVEL
                && link.attr_id <= RAC_IO_CMP_TOGGLE) begin
            for (int i = 0; i < CHANNELS; i++) begin
                if (link.instance_id == 8'(i + 1)) begin
                    unique case (link.attr_id)
                        RAC_IO_PIN_LEVEL: rd_val = {7'h00, pin_s2_r[i]};
                        RAC_IO_OUT_DRIVE: rd_val = {7'h00, drive_w[i]};
                        RAC_IO_CNT_CLEAR: rd_val = {7'h00, clr_w[i]};
                        RAC_IO_CMP_EXCEEDED: rd_val = {7'h00, exc_w[i]};
                        default: rd_val = {7'h00, tog_w[i]};
                    endcase
                end
            end
            if (is_set && (link.attr_id == RAC_IO_PIN_LEVEL || link.attr_id >= RAC_IO_CMP_EXCEEDED)) begin
                st_val = RAC_SVC_ERR_ATTR;
            end
        end else if (is_act && link.instance_id == 8'h00_01 && link.attr_id >= RAC_ACT_MODE
                && link.attr_id <= RAC_ACT_CLEAR) begin
            unique case (link.attr_id)
                RAC_ACT_MODE: rd_val = {7'h00, ack_mode_r};
                RAC_ACT_PENDING: rd_val = pending_r;
                RAC_ACT_GATE: rd_val = {7'h00, gate_bit_r};
                RAC_ACT_ACK: rd_val = {7'h00, ack_bit_r};
                default: rd_val = {7'h00, clear_bit_r};
            endcase
            if (is_set && link.attr_id == RAC_ACT_PENDING) begin
                st_val = RAC_SVC_ERR_ATTR;
            end
        end else begin
            st_val = RAC_SVC_ERR_ATTR;
        end
    end

    // response, one cycle after the request
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            link.rsp <= 1'b0;
            link.rsp_status <= RAC_SVC_OK;
            link.rdata <= 8'h00_00;
        end else begin
            link.rsp <= link.req;
            if (link.req) begin
                link.rsp_status <= st_val;
                link.rdata <= (is_get && st_val == RAC_SVC_OK) ? rd_val : 8'h00_00;
            end
        end
    end

    // ------------------------------------------------------------
    // configuration record and mode
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            ack_mode_r <= RAC_CFG_RESET[RAC_CFG_EN_BIT];
            result_fragment_en <= RAC_CFG_RESET[RAC_CFG_EN_BIT];
            entry_fragment_en <= RAC_CFG_RESET[RAC_CFG_EN_BIT];
        end else if (set_ok && is_cfg) begin
            unique case (link.attr_id)
                RAC_CFG_ACK_MODE_BYTE: ack_mode_r <= wbit;
                RAC_CFG_RESULT_FRAG_BYTE: result_fragment_en <= wbit;
                default: entry_fragment_en <= wbit;
            endcase
        end else if (set_ok && is_act && link.attr_id == RAC_ACT_MODE) begin
            ack_mode_r <= wbit;
        end
    end
    assign ack_mode = ack_mode_r;

    // activation control bits
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            gate_bit_r <= 1'b0;
            ack_bit_r <= 1'b0;
            clear_bit_r <= 1'b0;
        end else if (set_ok && is_act) begin
            if (link.attr_id == RAC_ACT_GATE) gate_bit_r <= wbit;
            if (link.attr_id == RAC_ACT_ACK) ack_bit_r <= wbit;
            if (link.attr_id == RAC_ACT_CLEAR) clear_bit_r <= wbit;
        end
    end
    assign reading_gate_open = gate_bit_r;
    assign switching_output = drive_w;

    // ------------------------------------------------------------
    // result queue count and input area
    // ------------------------------------------------------------
    assign take_new = !shown_valid_r || !ack_mode_r;

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            pending_r <= 8'h00_00;
        end else if (clear_rise) begin
            pending_r <= 8'h00_00;
        end else if (result_new && pending_r != 8'h00_FF && !(take_new && pending_r == 8'h00_00)) begin
            pending_r <= pending_r + 8'h00_01;
        end else if (!result_new && pending_r != 8'h00_00 && (take_new || ack_event)) begin
            pending_r <= pending_r - 8'h00_01;
        end
    end

    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            shown_r <= 8'h00_00;
            shown_valid_r <= 1'b0;
        end else if (clear_rise) begin
            shown_r <= 8'h00_00;
            shown_valid_r <= 1'b0;
        end else if (result_new && take_new) begin
            shown_r <= result_byte;
            shown_valid_r <= 1'b1;
        end else if (ack_mode_r && ack_event) begin
            if (pending_r == 8'h00_00) begin
                shown_r <= 8'h00_00;
                shown_valid_r <= 1'b0;
            end else begin
                shown_r <= queued_r;
                shown_valid_r <= 1'b1; // newest queued result stands
            end
        end
    end
    assign input_area = shown_r;
    assign input_area_valid = shown_valid_r;

    // newest waiting result
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) queued_r <= 8'h00_00;
        else if (result_new && !take_new) queued_r <= result_byte;
    end
endmodule
`default_nettype wire

// >>> rac_controller.sv
`timescale 1ns/10ps
`default_nettype none
// ------------------------------------------------------------
// controller end: software port to link requests
// ------------------------------------------------------------
module rac_controller
    import rac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    rac_link_if.controller link,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic wr,
    input wire logic rd,
    output logic [7:0] rdata
);
    logic [7:0] class_r, inst_r, attr_r, wd_r, rsp_data_r, rsp_st_r;
    logic busy_r, done_r;
    logic [1:0] cfg_idx_r;
    logic cfg_run_r;
    logic [7:0] cfg_shadow_r [RAC_CFG_LEN];

    // software registers
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            class_r <= 8'h00_00;
            inst_r <= 8'h00_00;
            attr_r <= 8'h00_00;
            wd_r <= 8'h00_00;
            for (int i = 0; i < RAC_CFG_LEN; i++) cfg_shadow_r[i] <= RAC_CFG_RESET;
        end else if (wr) begin
            if (addr == RAC_REG_CLASS) class_r <= wdata;
            if (addr == RAC_REG_INST) inst_r <= wdata;
            if (addr == RAC_REG_ATTR) attr_r <= wdata;
            if (addr == RAC_REG_WDATA) wd_r <= wdata;
            if (addr == RAC_REG_CFGSEND) begin
                cfg_shadow_r[0] <= {7'h00, wdata[0]};
                cfg_shadow_r[1] <= {7'h00, wdata[1]};
                cfg_shadow_r[2] <= {7'h00, wdata[2]};
            end
        end
    end

    // request issue, one in flight
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            link.req <= 1'b0;
            link.service <= RAC_SVC_GET;
            link.class_id <= 8'h00_00;
            link.instance_id <= 8'h00_00;
            link.attr_id <= 8'h00_00;
            link.wdata <= 8'h00_00;
            busy_r <= 1'b0;
            done_r <= 1'b0;
            cfg_idx_r <= 2'd0;
            cfg_run_r <= 1'b0;
            rsp_data_r <= 8'h00_00;
            rsp_st_r <= 8'h00_00;
        end else begin
            link.req <= 1'b0;
            if (link.rsp) begin
                busy_r <= 1'b0;
                done_r <= 1'b1;
                rsp_data_r <= link.rdata;
                rsp_st_r <= link.rsp_status;
            end
            if (wr && addr == RAC_REG_CMD && !busy_r && !cfg_run_r) begin
                link.req <= wdata[RAC_CMD_GET_BIT] | wdata[RAC_CMD_SET_BIT];
                link.service <= wdata[RAC_CMD_SET_BIT] ? RAC_SVC_SET : RAC_SVC_GET;
                link.class_id <= class_r;
                link.instance_id <= inst_r;
                link.attr_id <= attr_r;
                link.wdata <= wd_r;
                busy_r <= wdata[RAC_CMD_GET_BIT] | wdata[RAC_CMD_SET_BIT];
                done_r <= 1'b0;
            end else if (wr && addr == RAC_REG_CFGSEND && !busy_r) begin
                cfg_run_r <= 1'b1;
                cfg_idx_r <= 2'd0;
                done_r <= 1'b0;
            end else if (cfg_run_r && !busy_r && !link.req) begin
                link.req <= 1'b1;
                link.service <= RAC_SVC_SET;
                link.class_id <= RAC_CLASS_CFG;
                link.instance_id <= 8'h00_01;
                link.attr_id <= {6'h00, cfg_idx_r};
                link.wdata <= cfg_shadow_r[cfg_idx_r];
                busy_r <= 1'b1;
                cfg_idx_r <= cfg_idx_r + 2'd1;
                if (cfg_idx_r == 2'(RAC_CFG_LEN - 1)) cfg_run_r <= 1'b0;
            end
        end
    end

    // read data, one cycle after read strobe
    always_ff @(posedge clk_sys or negedge reset_n) begin
        if (!reset_n) begin
            rdata <= 8'h00_00;
        end else if (rd) begin
            unique case (addr)
                RAC_REG_CLASS: rdata <= class_r;
                RAC_REG_INST: rdata <= inst_r;
                RAC_REG_ATTR: rdata <= attr_r;
                RAC_REG_WDATA: rdata <= wd_r;
                RAC_REG_STATUS: rdata <= {6'h00, done_r, busy_r | cfg_run_r};
                RAC_REG_RDATA: rdata <= rsp_data_r;
                RAC_REG_CMD: rdata <= rsp_st_r;
                default: rdata <= 8'h00_00;
            endcase
        end else begin
            rdata <= 8'h00_00;
        end
    end
endmodule
`default_nettype wire

// >>> rac_link_sva.sv
`timescale 1ns/10ps
`default_nettype none
module rac_link_sva
    import rac_pkg::*;
(
    input wire logic clk_sys,
    input wire logic reset_n,
    input wire logic req,
    input wire logic [7:0] service,
    input wire logic [7:0] class_id,
    input wire logic [7:0] instance_id,
    input wire logic [7:0] attr_id,
    input wire logic [7:0] wdata,
    input wire logic rsp,
    input wire logic [7:0] rsp_status,
    input wire logic [7:0] rdata
);
    // ----------------------------------------
    // link answer checks
    // ----------------------------------------
    default clocking dcb @(posedge clk_sys); endclocking
    default disable iff (!reset_n);
    wire get_w = req && service == RAC_SVC_GET;
    answer_latency_a: assert property (req |=> rsp) else $error("link answer missing");
    no_spurious_rsp_a: assert property (rsp |-> $past(req)) else $error("answer without request");
    io_reserved_a: assert property (req && class_id == RAC_CLASS_IO && attr_id inside {[1:4]}
        |=> rsp_status == RAC_SVC_ERR_ATTR) else $error("reserved channel attribute accepted");
    cfg_length_a: assert property (req && class_id == RAC_CLASS_CFG && attr_id > 8'h02
        |=> rsp_status == RAC_SVC_ERR_ATTR) else $error("config byte beyond three");
    cfg_reserved_a: assert property (get_w && class_id == RAC_CLASS_CFG && attr_id < 8'h03
        |=> rdata[7:1] == 7'h00) else $error("reserved config bits nonzero");
    set_no_data_a: assert property (req && service == RAC_SVC_SET |=> rdata == 8'h00)
        else $error("data returned on set");
    count_readonly_a: assert property (req && service == RAC_SVC_SET && class_id == RAC_CLASS_ACT
        && attr_id == RAC_ACT_PENDING |=> rsp_status == RAC_SVC_ERR_ATTR) else $error("count written");
    bit_value_a: assert property (get_w && class_id == RAC_CLASS_IO && attr_id inside {[5:9]}
        && instance_id inside {[1:2]} |=> rdata[7:1] == 7'h00 && rsp_status == RAC_SVC_OK)
        else $error("channel bit malformed");
    cover property (req && service == RAC_SVC_SET && class_id == RAC_CLASS_CFG);
    cover property (get_w && class_id == RAC_CLASS_IO);
    cover property (req && class_id == RAC_CLASS_ACT && attr_id == RAC_ACT_ACK);
endmodule
`default_nettype wire

// >>> reader_activation_io_control_test.sv
`timescale 1ns/10ps
`default_nettype none
module reader_activation_io_control_test
    import rac_pkg::*;
;
    localparam logic [7:0] K = RAC_SVC_OK;
    localparam logic [7:0] E = RAC_SVC_ERR_ATTR;
    logic clk_sys = 0, reset_n = 0, wr = 0, rd = 0, result_new = 0, gate, valid, ack_m, rfr, efr;
    logic [3:0] addr = 4'h0;
    logic [7:0] wdata = 8'h00, result_byte = 8'h00, rdata, area, v, s;
    logic [1:0] pin = 2'h0, ev = 2'h0, sw;
    int fail_count = 0, total_checks = 0, cyc = 0;
    rac_link_if link ();
    rac_controller rac_controller_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(link.controller),
        .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata));
    rac_reader rac_reader_inst (.clk_sys(clk_sys), .reset_n(reset_n), .link(link.reader),
        .switched_channel_pin(pin), .channel_event(ev), .compare_value(16'h0002), .repeat_mode(1'b0),
        .result_new(result_new), .result_byte(result_byte), .switching_output(sw), .reading_gate_open(gate),
        .input_area(area), .input_area_valid(valid), .ack_mode(ack_m), .result_fragment_en(rfr),
        .entry_fragment_en(efr));
    rac_link_sva rac_link_sva_inst (.clk_sys(clk_sys), .reset_n(reset_n), .req(link.req),
        .service(link.service), .class_id(link.class_id), .instance_id(link.instance_id),
        .attr_id(link.attr_id), .wdata(link.wdata), .rsp(link.rsp), .rsp_status(link.rsp_status),
        .rdata(link.rdata));
    // ----------------------------------------
    // clock, timeout and access tasks
    // ----------------------------------------
    initial forever #20 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            complete_run();
        end
    end
    task automatic complete_run();
        $display("checks %0d mismatches %0d", total_checks, fail_count);
        if (fail_count == 0 && total_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    task automatic chk(input logic [8:0] seen, input logic [8:0] exp);
        total_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wrr(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk_sys) addr <= a;
        wdata <= d;
        wr <= 1'b1;
        @(posedge clk_sys) wr <= 1'b0;
    endtask
    task automatic rdr(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk_sys) addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys) rd <= 1'b0;
        #1 d = rdata;
    endtask
    // one attribute access and compare
    task automatic op(input logic [7:0] c, a, ev_v = 8'h00, es = K, d = 8'h00, input logic set = 1'b0,
        input logic [7:0] i = 8'h01);
        wrr(RAC_REG_CLASS, c);
        wrr(RAC_REG_INST, i);
        wrr(RAC_REG_ATTR, a);
        wrr(RAC_REG_WDATA, d);
        wrr(RAC_REG_CMD, set ? 8'h02 : 8'h01);
        s = 8'h01;
        for (int n = 0; n < 21 && s[0] !== 1'b0; n++) rdr(RAC_REG_STATUS, s);
        rdr(RAC_REG_RDATA, v);
        rdr(RAC_REG_CMD, s);
        chk(v, ev_v);
        chk(s, es);
    endtask
    task automatic pulse();
        repeat (5) @(posedge clk_sys) ev <= 2'h3;
        repeat (4) @(posedge clk_sys) ev <= 2'h0;
    endtask
    task automatic res(input logic [7:0] d);
        @(posedge clk_sys) {result_new, result_byte} <= {1'b1, d};
        repeat (4) @(posedge clk_sys) result_new <= 1'b0;
    endtask
    // ----------------------------------------
    // test sequence
    // ----------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys);
        reset_n <= 1'b1;
        for (int k = 0; k < 3; k++) begin
            op(RAC_CLASS_CFG, k[7:0]);
            op(RAC_CLASS_CFG, k[7:0], 8'h00, K, 8'hFF, 1'b1);
            op(RAC_CLASS_CFG, k[7:0], 8'h01);
        end
        chk({5'h00, efr, rfr, ack_m}, 8'h07);
        op(RAC_CLASS_CFG, 8'h03, 8'h00, E);
        $display("test config done");
        pin <= 2'h2;
        for (int k = 1; k < 5; k++) op(RAC_CLASS_IO, k[7:0], 8'h00, E);
        op(RAC_CLASS_IO, RAC_IO_PIN_LEVEL);
        op(RAC_CLASS_IO, RAC_IO_PIN_LEVEL, 8'h01, K, 8'h00, 1'b0, 8'h02);
        op(RAC_CLASS_IO, RAC_IO_OUT_DRIVE, 8'h00, K, 8'h01, 1'b1);
        chk({6'h00, sw}, 8'h01);
        repeat (2) pulse();
        op(RAC_CLASS_IO, RAC_IO_CMP_EXCEEDED);
        pulse();
        op(RAC_CLASS_IO, RAC_IO_CMP_EXCEEDED, 8'h01);
        op(RAC_CLASS_IO, RAC_IO_CMP_TOGGLE, 8'h01);
        op(RAC_CLASS_IO, RAC_IO_CNT_CLEAR, 8'h00, K, 8'h01, 1'b1);
        op(RAC_CLASS_IO, RAC_IO_CMP_EXCEEDED);
        op(RAC_CLASS_IO, RAC_IO_CMP_TOGGLE);
        $display("test channel done");
        op(RAC_CLASS_ACT, RAC_ACT_GATE, 8'h00, K, 8'h01, 1'b1);
        chk({7'h00, gate}, 8'h01);
        op(RAC_CLASS_ACT, RAC_ACT_GATE, 8'h00, K, 8'h00, 1'b1);
        chk({7'h00, gate}, 8'h00);
        op(RAC_CLASS_ACT, RAC_ACT_PENDING, 8'h00, E, 8'h05, 1'b1);
        res(8'hA5);
        res(8'h5A);
        chk(area, 8'hA5);
        op(RAC_CLASS_ACT, RAC_ACT_ACK, 8'h00, K, 8'h01, 1'b1);
        chk(area, 8'h5A);
        op(RAC_CLASS_ACT, RAC_ACT_ACK, 8'h00, K, 8'h00, 1'b1);
        chk(area, 8'h00);
        op(RAC_CLASS_ACT, RAC_ACT_PENDING);
        res(8'h3C);
        op(RAC_CLASS_ACT, RAC_ACT_CLEAR, 8'h00, K, 8'h01, 1'b1);
        chk({valid, area}, 9'h000);
        $display("test activation done");
        complete_run();
    end
endmodule
`default_nettype wire
